// ---- rfts_pkg.sv ----
// Overview of operation
// - Plain frame sync when non-interlaced, tessellated sync with equalisation when interlaced.
// - Vertical counts are in half-lines; 1024 visible lines programmed as 2048.
// - In interlace the vertical display count describes one field, e.g. 625.
// - Both equalisations and vsync last the vsync count; back porch has its own.
// - In interlace, sync low lasts broad pulse in vsync, half-sync in equalisation half-lines.
// - Interlaced equalisation and vsync loops last half a line; a display half-line uses short display count.
// - Timing parameters are read and written only while the sequencer is disabled.
// - Enabling starts the sequencer immediately at the beginning of frame sync.
// - Mode-only changes skip rewrites; other locations writable while running.
// - Horizontal counts are in screen units of four pixels, one per clock.
// - Line sync is half-sync twice; line ends when line time expires.
// - Frame flyback flag is high whenever the display is in frame flyback.
package rfts_pkg;
  localparam int AW = 9;
  localparam int DW = 24;
  localparam logic [AW-1:0] ADDR_TP_BASE = 9'h120;
  localparam logic [3:0] IX_HALFSYNC = 4'h1;
  localparam logic [3:0] IX_BACKPORCH = 4'h2;
  localparam logic [3:0] IX_DISPLAY = 4'h3;
  localparam logic [3:0] IX_SHORTDISP = 4'h4;
  localparam logic [3:0] IX_BROADPULSE = 4'h5;
  localparam logic [3:0] IX_VSYNC = 4'h6;
  localparam logic [3:0] IX_VBLANK = 4'h7;
  localparam logic [3:0] IX_VVISIBLE = 4'h8;
  localparam logic [3:0] IX_LINETIME = 4'h9;
  localparam logic [3:0] IX_TOPSCREEN = 4'hA;
  localparam logic [3:0] IX_MEMINIT = 4'hB;
  localparam logic [3:0] IX_VRAM_LEAD = 4'hC;
  localparam logic [AW-1:0] ADDR_CONTROL = 9'h160;
  localparam logic [AW-1:0] ADDR_BOOT = 9'h1A0;
  localparam logic [AW-1:0] ADDR_STATUS = 9'h1C0;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_INTERLACE_BIT = 1;
  localparam int CTRL_PORT_WORD_BIT = 7;
  localparam logic [DW-1:0] CTRL_RESET = 24'h000000;
  localparam logic [DW-1:0] BOOT_RESET = 24'h000000;
  localparam int STAT_ENABLE_BIT = 0;
  localparam int STAT_FLYBACK_BIT = 1;
  localparam int STAT_FIELD_BIT = 2;
  localparam int STAT_BOOTED_BIT = 3;
  typedef enum logic [2:0] {
    VP_PRE_EQ,
    VP_VSYNC,
    VP_POST_EQ,
    VP_VBACK,
    VP_VDISP
  } rfts_vphase_t;
endpackage : rfts_pkg

// ---- rfts_halfline_timer.sv ----
`timescale 1ns/1ps
module rfts_halfline_timer #(
  parameter int TW = 12
) (
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  input wire logic run_in,
  input wire logic [TW-1:0] period_in,
  output logic [TW-1:0] count_out,
  output logic last_out
);
  logic [TW-1:0] count_ff;

  if (TW < 4) begin : g_chk
    $error("rfts_halfline_timer: TW too small");
  end

  // Period of zero wraps to the longest period, 2^TW clocks; parameters are non-zero by contract
  assign last_out = run_in && (count_ff == period_in - 1'b1);
  assign count_out = count_ff;

  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
      count_ff <= '0;
    else if (ce_in)
    begin
      if (!run_in || last_out)
        count_ff <= '0;
      else
        count_ff <= count_ff + 1'b1;
    end
  end
endmodule : rfts_halfline_timer

// ---- rfts_raster_sequencer.sv ----
// Design decisions made here: the placing of the registers and strobed register access.
`timescale 1ns/1ps
module rfts_raster_sequencer #(
  parameter int TW = 12
) (
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  input wire logic [rfts_pkg::AW-1:0] reg_addr_in,
  input wire logic [rfts_pkg::DW-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [rfts_pkg::DW-1:0] reg_rdata_out,
  output logic comp_sync_n_out,
  output logic frame_sync_n_out,
  output logic comp_blank_out,
  output logic frame_flyback_flag_out,
  output logic field_odd_out,
  output logic vram_load_out,
  output logic host_port_word_out,
  output logic [rfts_pkg::DW-1:0] boot_config_out
);
  import rfts_pkg::*;

  // Read path pads parameters with at least one zero bit
  if (TW < 4 || TW >= DW) begin : g_chk
    $error("rfts_raster_sequencer: TW must lie in 4..DW-1");
  end

  localparam int SW = TW + 2;

  logic [TW-1:0] tp_ff [1:12];
  logic [DW-1:0] ctrl_ff;
  logic [DW-1:0] boot_ff;
  logic booted_ff;
  logic [DW-1:0] rdata_ff;
  rfts_vphase_t phase_ff;
  logic [TW-1:0] vrem_ff;
  logic full_ff;
  logic field_ff;
  logic sync_n_ff;
  logic fsync_n_ff;
  logic blank_ff;
  logic flyback_ff;
  logic load_ff;

  logic run;
  logic tess;
  logic [TW-1:0] hc;
  logic hlast;
  logic [TW-1:0] period;
  logic tp_hit;
  logic [3:0] tp_ix;

  function automatic logic is_tp(input logic [AW-1:0] a);
    is_tp = (a[AW-1:4] == ADDR_TP_BASE[AW-1:4]) && (a[3:0] >= IX_HALFSYNC)
            && (a[3:0] <= IX_VRAM_LEAD);
  endfunction : is_tp

  // Half-lines a vertical phase lasts
  function automatic logic [TW-1:0] phase_len(input rfts_vphase_t p);
    unique case (p)
      VP_PRE_EQ, VP_VSYNC, VP_POST_EQ: phase_len = tp_ff[IX_VSYNC];
      VP_VBACK: phase_len = tp_ff[IX_VBLANK];
      VP_VDISP: phase_len = tp_ff[IX_VVISIBLE];
    endcase
  endfunction : phase_len

  // Full line when two or more half-lines remain, except in tessellated equalisation and vsync
  function automatic logic is_full(input rfts_vphase_t p, input logic [TW-1:0] rem,
                                   input logic t);
    is_full = (!t || p == VP_VBACK || p == VP_VDISP) && (rem >= 2);
  endfunction : is_full

  function automatic rfts_vphase_t next_phase(input rfts_vphase_t p);
    unique case (p)
      VP_PRE_EQ: next_phase = VP_VSYNC;
      VP_VSYNC: next_phase = VP_POST_EQ;
      VP_POST_EQ: next_phase = VP_VBACK;
      VP_VBACK: next_phase = VP_VDISP;
      VP_VDISP: next_phase = VP_PRE_EQ;
    endcase
  endfunction : next_phase

  assign run = ctrl_ff[CTRL_ENABLE_BIT];
  assign tess = ctrl_ff[CTRL_INTERLACE_BIT];
  assign tp_hit = is_tp(reg_addr_in);
  assign tp_ix = reg_addr_in[3:0];
  // Odd line time would lose a clock per pair of half lines; host keeps it even
  assign period = full_ff ? tp_ff[IX_LINETIME] : (tp_ff[IX_LINETIME] >> 1);

  ////////////////////////////////////////////////////////////////////////////
  // Register port

  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      for (int i = 1; i <= 12; i++)
        tp_ff[i] <= '0;
    end
    else if (ce_in && reg_wr_in && tp_hit && !run)
      tp_ff[tp_ix] <= reg_wdata_in[TW-1:0];
  end

  // Control and boot stay writable while running
  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      ctrl_ff <= CTRL_RESET;
      boot_ff <= BOOT_RESET;
      booted_ff <= 1'b0;
    end
    else if (ce_in && reg_wr_in)
    begin
      if (reg_addr_in == ADDR_CONTROL)
        ctrl_ff <= reg_wdata_in;
      if (reg_addr_in == ADDR_BOOT)
      begin
        boot_ff <= reg_wdata_in;
        booted_ff <= 1'b1;
      end
    end
  end

  // Boot location is write only; parameters read as zero while running
  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
      rdata_ff <= '0;
    else if (ce_in)
    begin
      rdata_ff <= '0;
      if (reg_rd_in)
      begin
        if (tp_hit && !run)
          rdata_ff <= {{(DW-TW){1'b0}}, tp_ff[tp_ix]};
        else if (reg_addr_in == ADDR_CONTROL)
          rdata_ff <= ctrl_ff;
        else if (reg_addr_in == ADDR_STATUS)
        begin
          rdata_ff[STAT_ENABLE_BIT] <= run;
          rdata_ff[STAT_FLYBACK_BIT] <= flyback_ff;
          rdata_ff[STAT_FIELD_BIT] <= field_ff;
          rdata_ff[STAT_BOOTED_BIT] <= booted_ff;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Horizontal counter, one count per screen unit

  rfts_halfline_timer #(
    .TW(TW)
  ) u_timer (
    .clock_in(clock_in),
    .rstn_in(rstn_in),
    .ce_in(ce_in),
    .run_in(run),
    .period_in(period),
    .count_out(hc),
    .last_out(hlast)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Vertical sequence in half-lines

  // Held at the start of vsync while disabled, so enabling starts there
  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      phase_ff <= VP_VSYNC;
      vrem_ff <= '0;
      full_ff <= 1'b0;
    end
    else if (ce_in)
    begin
      if (!run)
      begin
        phase_ff <= VP_VSYNC;
        vrem_ff <= tp_ff[IX_VSYNC];
        full_ff <= is_full(VP_VSYNC, tp_ff[IX_VSYNC], tess);
      end
      else if (hlast)
      begin
        if (vrem_ff <= (full_ff ? 2 : 1))
        begin
          phase_ff <= next_phase(phase_ff);
          vrem_ff <= phase_len(next_phase(phase_ff));
          full_ff <= is_full(next_phase(phase_ff), phase_len(next_phase(phase_ff)), tess);
        end
        else
        begin
          vrem_ff <= vrem_ff - (full_ff ? 2'd2 : 2'd1);
          full_ff <= is_full(phase_ff, vrem_ff - (full_ff ? 2'd2 : 2'd1), tess);
        end
      end
    end
  end

  // Odd half-line count per field gives the half-line offset between fields
  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
      field_ff <= 1'b0;
    else if (ce_in)
    begin
      if (!run || !tess)
        field_ff <= 1'b0;
      else if (hlast && phase_ff == VP_VDISP && vrem_ff <= (full_ff ? 2 : 1))
        field_ff <= !field_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sync, blank and transfer decode

  logic [SW-1:0] hcx;
  logic [SW-1:0] hs2;
  logic [SW-1:0] disp_start;
  logic [SW-1:0] disp_end;
  logic nxt_sync_low;
  logic nxt_visible;
  logic nxt_load;

  assign hcx = {2'b00, hc};
  assign hs2 = {1'b0, tp_ff[IX_HALFSYNC], 1'b0};
  assign disp_start = hs2 + {2'b00, tp_ff[IX_BACKPORCH]};
  assign disp_end = disp_start + {2'b00, full_ff ? tp_ff[IX_DISPLAY] : tp_ff[IX_SHORTDISP]};

  always_comb
  begin
    if (tess && phase_ff == VP_VSYNC)
      nxt_sync_low = hcx < {2'b00, tp_ff[IX_BROADPULSE]};
    else if (tess && !full_ff && (phase_ff == VP_PRE_EQ || phase_ff == VP_POST_EQ))
      nxt_sync_low = hcx < {2'b00, tp_ff[IX_HALFSYNC]};
    else if (!tess && phase_ff == VP_VSYNC)
      nxt_sync_low = 1'b1;
    else
      nxt_sync_low = hcx < hs2;
  end

  assign nxt_visible = (phase_ff == VP_VDISP) && (hcx >= disp_start) && (hcx < disp_end);
  // Transfer leads the display by the programmed lead; porch exceeds it
  assign nxt_load = (phase_ff == VP_VDISP)
                    && (hcx == disp_start - {2'b00, tp_ff[IX_VRAM_LEAD]});

  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      sync_n_ff <= 1'b1;
      fsync_n_ff <= 1'b1;
      blank_ff <= 1'b1;
      flyback_ff <= 1'b1;
      load_ff <= 1'b0;
    end
    else if (ce_in)
    begin
      sync_n_ff <= !(run && nxt_sync_low);
      fsync_n_ff <= !(run && phase_ff == VP_VSYNC);
      blank_ff <= !(run && nxt_visible);
      flyback_ff <= !run || phase_ff != VP_VDISP;
      load_ff <= run && nxt_load;
    end
  end

  assign reg_rdata_out = rdata_ff;
  assign comp_sync_n_out = sync_n_ff;
  assign frame_sync_n_out = fsync_n_ff;
  assign comp_blank_out = blank_ff;
  assign frame_flyback_flag_out = flyback_ff;
  assign field_odd_out = field_ff;
  assign vram_load_out = load_ff;
  assign host_port_word_out = ctrl_ff[CTRL_PORT_WORD_BIT];
  assign boot_config_out = boot_ff;
endmodule : rfts_raster_sequencer

// ---- rfts_seq_checker.sv ----
`timescale 1ns/1ps
module rfts_seq_checker (
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  input wire logic [rfts_pkg::AW-1:0] reg_addr_in,
  input wire logic [rfts_pkg::DW-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [rfts_pkg::DW-1:0] reg_rdata_out,
  input wire logic comp_sync_n_out,
  input wire logic frame_sync_n_out,
  input wire logic comp_blank_out,
  input wire logic frame_flyback_flag_out,
  input wire logic field_odd_out,
  input wire logic vram_load_out,
  input wire logic host_port_word_out,
  input wire logic [rfts_pkg::DW-1:0] boot_config_out
);
  import rfts_pkg::*;
  logic en_ff;
  logic ctl_wr;
  assign ctl_wr = ce_in && reg_wr_in && reg_addr_in == ADDR_CONTROL;
  // Enable as last written, so a restart is told apart from a mode change
  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
      en_ff <= 1'b0;
    else if (ctl_wr)
      en_ff <= reg_wdata_in[CTRL_ENABLE_BIT];
  end
  ////////////////////////////////////////
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rstn_in);
  a_rdata_idle: assert property (ce_in && !reg_rd_in |=> reg_rdata_out == '0)
    else $error("read data not idle");
  a_boot_hidden: assert property (ce_in && reg_rd_in && reg_addr_in == ADDR_BOOT
    |=> reg_rdata_out == '0) else $error("boot location readable");
  a_param_locked: assert property (en_ff && ce_in && reg_rd_in
    && reg_addr_in inside {[9'h121:9'h12C]} |=> reg_rdata_out == '0)
    else $error("parameter readable while running");
  a_boot_capture: assert property (ce_in && reg_wr_in && reg_addr_in == ADDR_BOOT
    |=> boot_config_out == $past(reg_wdata_in)) else $error("boot pattern lost");
  a_port_width: assert property (ctl_wr
    |=> host_port_word_out == $past(reg_wdata_in[CTRL_PORT_WORD_BIT]))
    else $error("port width wrong");
  a_start_vsync: assert property (ctl_wr && !en_ff && reg_wdata_in[0]
    |-> ##2 !frame_sync_n_out && frame_flyback_flag_out) else $error("no frame sync start");
  a_disable_idle: assert property (ctl_wr && !reg_wdata_in[0]
    |-> ##2 frame_sync_n_out && comp_sync_n_out && comp_blank_out && frame_flyback_flag_out)
    else $error("outputs not idle");
  a_blank_flyback: assert property (frame_flyback_flag_out |-> comp_blank_out)
    else $error("visible during flyback");
  a_fsync_flyback: assert property (!frame_sync_n_out |-> frame_flyback_flag_out)
    else $error("frame sync outside flyback");
  a_load_pulse: assert property (vram_load_out
    |-> !frame_flyback_flag_out ##1 !vram_load_out) else $error("bad load pulse");
endmodule : rfts_seq_checker

bind rfts_raster_sequencer rfts_seq_checker i_chk (.clock_in, .rstn_in, .ce_in,
  .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .comp_sync_n_out,
  .frame_sync_n_out, .comp_blank_out, .frame_flyback_flag_out, .field_odd_out,
  .vram_load_out, .host_port_word_out, .boot_config_out);

// ---- rfts_monitor_model.sv ----
`timescale 1ns/1ps
module rfts_monitor_model (
  input wire logic clock_in,
  input wire logic clr_in,
  input wire logic sync_n_in,
  input wire logic fsync_n_in,
  input wire logic blank_in,
  input wire logic flyback_in,
  output int per_out,
  output int low_out,
  output int vis_out,
  output int fly_min_out,
  output int fly_max_out
);
  int low_n;
  int vis_n;
  int per_n;
  logic sync_q;
  logic blank_q;
  logic fs_q;
  // Receive only: a monitor drives nothing back, it measures what it sees
  always @(posedge clock_in)
  begin
    sync_q <= sync_n_in;
    blank_q <= blank_in;
    fs_q <= fsync_n_in;
    low_n <= sync_n_in ? 0 : low_n + 1;
    vis_n <= blank_in ? 0 : vis_n + 1;
    per_n <= (fs_q && !fsync_n_in) ? 1 : per_n + 1;
    if (fs_q && !fsync_n_in)
      per_out <= per_n;
    if (sync_n_in && !sync_q && !flyback_in)
      low_out <= low_n;
    if (sync_n_in && !sync_q && flyback_in && low_n < fly_min_out)
      fly_min_out <= low_n;
    if (sync_n_in && !sync_q && flyback_in && low_n > fly_max_out)
      fly_max_out <= low_n;
    if (blank_in && !blank_q)
      vis_out <= vis_n;
    if (clr_in)
    begin
      fly_min_out <= 1000;
      fly_max_out <= 0;
    end
  end
endmodule : rfts_monitor_model

// ---- tb_raster_frame_timing_sequencer.sv ----
`timescale 1ns/1ps
module tb_raster_frame_timing_sequencer;
  import rfts_pkg::*;
  typedef struct {logic [8:0] a; logic [23:0] d; logic [23:0] e;} rfts_row_t;
  logic clock_in, rstn_in, ce_in, wr, rd, mclr, f0;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata, rdata, boot;
  logic sync_n, fsync_n, blank, fly, field, load, word;
  int per, low, vis, fmin, fmax, mismatches, check_count;
  logic [5:0] snap;
  rfts_row_t rows [13];
  rfts_raster_sequencer i_dut (.clock_in(clock_in), .rstn_in(rstn_in), .ce_in(ce_in),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .comp_sync_n_out(sync_n), .frame_sync_n_out(fsync_n),
    .comp_blank_out(blank), .frame_flyback_flag_out(fly), .field_odd_out(field),
    .vram_load_out(load), .host_port_word_out(word), .boot_config_out(boot));
  rfts_monitor_model i_mon (.clock_in(clock_in), .clr_in(mclr), .sync_n_in(sync_n),
    .fsync_n_in(fsync_n), .blank_in(blank), .flyback_in(fly), .per_out(per),
    .low_out(low), .vis_out(vis), .fly_min_out(fmin), .fly_max_out(fmax));
  ////////////////////////////////////////
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [8:0] a, input logic [23:0] d);
    @(posedge clock_in);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock_in);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [8:0] a, input logic [23:0] e);
    @(posedge clock_in);
    rd <= 1'b1;
    addr <= a;
    @(posedge clock_in);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask : rd_reg
  // Flyback sync minimum and maximum restart here, so stale figures from the old mode cannot pass
  task automatic settle_run();
    mclr <= 1'b1;
    @(posedge clock_in);
    mclr <= 1'b0;
    repeat (400) @(posedge clock_in);
    #1;
  endtask : settle_run
  task automatic wrap_up();
    if (mismatches == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up
  ////////////////////////////////////////
  initial
  begin
    clock_in = 1'b0;
    forever #2.5 clock_in = ~clock_in;
  end
  initial
  begin
    repeat (4000) @(posedge clock_in);
    mismatches++;
    wrap_up();
  end
  // Line 16 units, half line 8 sits between 4 and 12; lead below porch
  initial
  begin
    rows = '{'{9'h121, 24'h1, 24'h1}, '{9'h122, 24'h2, 24'h2}, '{9'h123, 24'h8, 24'h8},
      '{9'h124, 24'h2, 24'h2}, '{9'h125, 24'h6, 24'h6}, '{9'h126, 24'h3, 24'h3},
      '{9'h127, 24'h2, 24'h2}, '{9'h128, 24'h4, 24'h4}, '{9'h129, 24'h10, 24'h10},
      '{9'h12A, 24'h1, 24'h1}, '{9'h12B, 24'h1, 24'h1}, '{9'h12C, 24'h1, 24'h1},
      '{9'h1FF, 24'h5, 24'h0}};
    ce_in = 1'b1;
    rstn_in = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    mclr = 1'b0;
    addr = '0;
    wdata = '0;
    repeat (12) @(posedge clock_in);
    rstn_in <= 1'b1;
    wr_reg(ADDR_BOOT, 24'h00A5C3);
    #1 chk(boot, 24'h00A5C3);
    rd_reg(ADDR_BOOT, 24'h0);
    repeat (20) @(posedge clock_in);
    wr_reg(ADDR_CONTROL, 24'h80);
    #1 chk({23'h0, word}, 24'h1);
    foreach (rows[i])
    begin
      wr_reg(rows[i].a, rows[i].d);
      rd_reg(rows[i].a, rows[i].e);
    end
    wr_reg(ADDR_CONTROL, 24'h81);
    wr_reg(9'h121, 24'h5);
    rd_reg(9'h121, 24'h0);
    settle_run();
    chk(24'(per), 24'h78);
    chk(24'(low), 24'h2);
    chk(24'(vis), 24'h8);
    chk(24'(fmin), 24'h2);
    chk(24'(fmax), 24'h1A);
    chk({23'h0, field}, 24'h0);
    // Five visible of seventeen half-lines a field: odd frames of five and seventeen lines
    wr_reg(ADDR_CONTROL, 24'h80);
    wr_reg(9'h128, 24'h5);
    wr_reg(9'h127, 24'h3);
    wr_reg(ADDR_CONTROL, 24'h83);
    // Freeze inside the first vsync half-lines, where no load pulse can fall
    repeat (4) @(posedge clock_in);
    #1 snap = {sync_n, fsync_n, blank, fly, field, load};
    ce_in <= 1'b0;
    repeat (20) @(posedge clock_in);
    #1 chk({18'h0, sync_n, fsync_n, blank, fly, field, load}, {18'h0, snap});
    ce_in <= 1'b1;
    // The frozen pulse is stretched; let it end before measurements restart
    repeat (8) @(posedge clock_in);
    settle_run();
    chk(24'(per), 24'h88);
    chk(24'(fmin), 24'h1);
    chk(24'(fmax), 24'h6);
    f0 = field;
    repeat (136) @(posedge clock_in);
    #1 chk({23'h0, field}, {23'h0, ~f0});
    wr_reg(ADDR_CONTROL, 24'h80);
    rd_reg(9'h121, 24'h1);
    rd_reg(9'h128, 24'h5);
    rd_reg(9'h127, 24'h3);
    // A new clock factor means a full restart, reset included
    rstn_in <= 1'b0;
    repeat (3) @(posedge clock_in);
    #1 chk(boot, BOOT_RESET);
    chk({18'h0, sync_n, fsync_n, blank, fly, field, load}, 24'h3C);
    chk({23'h0, word}, 24'h0);
    @(posedge clock_in);
    rstn_in <= 1'b1;
    wr_reg(ADDR_BOOT, 24'h005A3C);
    #1 chk(boot, 24'h005A3C);
    wrap_up();
  end
endmodule : tb_raster_frame_timing_sequencer
